// File: abpc_checker.v
// Bus access protection checker top: descriptors, checks, error records, registers.
// Operation
// - Sixteen 128-bit region descriptors, every reference checked against all.
// - Each region bounded by start and end address, 32 bytes to 4 GB.
// - After reset the checker is disabled and all references pass.
// - Core master has read, write, execute rights per supervisor and user.
// - Other masters have only read and write rights, never execute.
// - Hardware drops the valid bit on each bound or rights write, except through the alias, so half-written descriptors are unused.
// - An alias of the access word changes rights only, not the bounds.
// - Overlapping regions: any granting region allows the reference.
// - Both the SRAM port and the peripheral bridge port are checked.
// - Error when no valid region hits or all hits deny the access.
// - On error the transfer ends with error response, slave never sees it.
// - Each port keeps a 64-bit record of the last violation.
// - Permitted references are forwarded and complete normally.
`timescale 1ns/100ps
`include "abpc_consts.vh"
module abpc_checker #(
  parameter NREG = `ABPC_NREG
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire irq,
  input wire [1:0] p_hsel,
  input wire [63:0] p_haddr,
  input wire [3:0] p_htrans,
  input wire [1:0] p_hwrite,
  input wire [1:0] p_hprot_data,
  input wire [1:0] p_hprot_priv,
  input wire [7:0] p_hmaster,
  input wire [1:0] p_hready,
  output wire [1:0] p_hreadyout,
  output wire [1:0] p_hresp,
  output wire [1:0] s_hsel,
  input wire [1:0] s_hreadyout,
  input wire [1:0] s_hresp
);
  // Register map, byte addresses on the register bus:
  // Offset 0x000 is control, and its bit 0 turns checking on.
  // Offset 0x004 holds the pending faults, one bit per port, written one to clear.
  // Offset 0x008 is the interrupt mask, with the layout of the pending bits.
  // Offsets 0x010 and 0x014 hold address and detail of the last fault on port 0.
  // Offsets 0x018 and 0x01c hold address and detail of the last fault on port 1.
  // Descriptor n sits at 0x400 plus 16n: start, end, rights and valid words.
  // The alias of the rights word of descriptor n sits at 0x800 plus 4n.
  // Port 0 is the SRAM port and port 1 the peripheral bridge port.
  // Master code zero is the processor core; every other code is a non-core master.
  localparam [3:0] CORE_ID = 4'h0;
  reg enable;
  reg [31:0] rgd_start [0:NREG-1];
  reg [31:0] rgd_end [0:NREG-1];
  reg [7:0] rgd_acc [0:NREG-1];
  reg [NREG-1:0] rgd_valid;
  reg [1:0] status;
  reg [1:0] next_status;
  reg [1:0] mask;
  reg [31:0] err_addr [0:1];
  reg [31:0] err_det [0:1];
  reg bus_wr;
  reg [11:0] bus_addr;
  wire [1:0] fault;
  wire [1:0] allow;
  wire [NREG-1:0] hit_v [0:1];
  wire [NREG-1:0] grant_v [0:1];
  wire bus_req;
  wire [3:0] w_idx;
  wire [1:0] w_sel;
  assign bus_req = hsel && htrans[1] && hready;
  assign w_idx = bus_addr[7:4];
  assign w_sel = bus_addr[3:2];
  // The register slave always answers at once with OKAY.
  assign hreadyout = 1'b1;
  assign hresp = `ABPC_HRESP_OKAY;
  assign irq = |(status & mask);

  // Capture the address phase for the data phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr <= 1'b0;
      bus_addr <= 12'h000;
    end else if (hready) begin
      bus_wr <= bus_req && hwrite;
      bus_addr <= haddr[11:0];
    end
  end

  // Two ports, each checked against every descriptor.
  genvar p;
  genvar r;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      wire is_core;
      assign is_core = (p_hmaster[p*4 +: 4] == CORE_ID);
      for (r = 0; r < NREG; r = r + 1) begin : g_rgd
        abpc_region_match u_match (
          .addr(p_haddr[p*32 +: 32]),
          .start_addr(rgd_start[r]),
          .end_addr(rgd_end[r]),
          .acc(rgd_acc[r]),
          .valid(rgd_valid[r]),
          .is_core(is_core),
          .priv(p_hprot_priv[p]),
          .is_write(p_hwrite[p]),
          .is_fetch(!p_hprot_data[p]),
          .hit(hit_v[p][r]),
          .grant(grant_v[p][r])
        );
      end
      // The decision is made in the address phase from the live address, so a
      // denied transfer never raises the slave select, not even for one cycle.
      // grant wins, disabled passes, miss or deny
      assign allow[p] = !enable || (|grant_v[p]);
      // both ports, error and block, forward
      abpc_port_gate u_gate (
        .hclk(hclk),
        .hresetn(hresetn),
        .m_hsel(p_hsel[p]),
        .m_htrans(p_htrans[p*2 +: 2]),
        .m_hready(p_hready[p]),
        .allow(allow[p]),
        .s_hreadyout(s_hreadyout[p]),
        .s_hresp(s_hresp[p]),
        .s_hsel(s_hsel[p]),
        .m_hreadyout(p_hreadyout[p]),
        .m_hresp(p_hresp[p]),
        .fault(fault[p])
      );
    end
  endgenerate

  // Detail word of a fault record: bits 31 to 16 the regions that were hit,
  // bits 7 to 4 the master code, bit 2 supervisor, bit 1 data, bit 0 write.
  // Only the newest fault is kept; older ones are lost if software is slow.
  // last fault record
  integer k;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (k = 0; k < 2; k = k + 1) begin
        err_addr[k] <= 32'h00000000;
        err_det[k] <= 32'h00000000;
      end
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        if (fault[k]) begin
          err_addr[k] <= p_haddr[k*32 +: 32];
          err_det[k] <= {hit_v[k], 8'h00, p_hmaster[k*4 +: 4], 1'b0,
                         p_hprot_priv[k], p_hprot_data[k], p_hwrite[k]};
        end
      end
    end
  end

  always @* begin
    next_status = status;
    if (bus_wr && (bus_addr == `ABPC_REG_STAT)) begin
      next_status = status & ~hwdata[1:0];
    end
    next_status = next_status | fault;
  end

  // Pending flags; a fault in the cycle of a clear keeps its bit set.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= 2'h0;
    end else begin
      status <= next_status;
    end
  end

  // Control and mask registers; disabled out of reset.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable <= 1'b0;
      mask <= 2'b00;
    end else if (bus_wr) begin
      if (bus_addr == `ABPC_REG_CTRL) begin
        enable <= hwdata[0];
      end
      if (bus_addr == `ABPC_REG_MASK) begin
        mask <= hwdata[1:0];
      end
    end
  end

  // Rights word bits: 0 to 2 supervisor read, write and execute; 3 to 5 the same
  // for user mode; 6 and 7 read and write for every non-core master.
  // A bound or rights write drops the valid bit, so software rewrites a region
  // and only then marks it valid; checks never see a half-updated descriptor.
  // The alias path leaves the valid bit alone, which lets rights change on a
  // live region in one write, at the cost of no atomic update of the bounds.
  // Descriptor writes: word 0 and 1 bounds, word 2 rights, word 3 valid.
  genvar d;
  generate
    for (d = 0; d < NREG; d = d + 1) begin : g_desc
      wire in_rgd;
      wire in_alt;
      assign in_rgd = bus_wr && (bus_addr[11:8] == `ABPC_RGD_BASE >> 8) && (w_idx == d);
      assign in_alt = bus_wr && (bus_addr[11:6] == `ABPC_ALT_BASE >> 6) &&
                      (bus_addr[5:2] == d);
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rgd_start[d] <= 32'h00000000;
          rgd_end[d] <= 32'h00000000;
          rgd_acc[d] <= 8'h00;
          rgd_valid[d] <= 1'b0;
        end else if (in_rgd) begin
          // start and end bounds, bound writes drop valid
          if (w_sel == `ABPC_W_START) begin
            rgd_start[d] <= hwdata & ~`ABPC_GRAN_MASK;
            rgd_valid[d] <= 1'b0;
          end
          if (w_sel == `ABPC_W_END) begin
            rgd_end[d] <= hwdata | `ABPC_GRAN_MASK;
            rgd_valid[d] <= 1'b0;
          end
          if (w_sel == `ABPC_W_ACC) begin
            rgd_acc[d] <= hwdata[7:0];
            rgd_valid[d] <= 1'b0;
          end
          if (w_sel == `ABPC_W_VLD) begin
            rgd_valid[d] <= hwdata[0];
          end
        end else if (in_alt) begin
          rgd_acc[d] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  // The read data is decoded from the captured address, so it stands for the
  // whole data phase and the register slave never needs a wait state.
  // Read data, decoded in the data phase; unmapped words read zero.
  always @* begin
    hrdata = 32'h00000000;
    if (bus_addr[11:8] == `ABPC_RGD_BASE >> 8) begin
      case (w_sel)
        `ABPC_W_START: hrdata = rgd_start[w_idx];
        `ABPC_W_END: hrdata = rgd_end[w_idx];
        `ABPC_W_ACC: hrdata = {24'h000000, rgd_acc[w_idx]};
        default: hrdata = {31'h00000000, rgd_valid[w_idx]};
      endcase
    end else if (bus_addr[11:6] == `ABPC_ALT_BASE >> 6) begin
      hrdata = {24'h000000, rgd_acc[bus_addr[5:2]]};
    end else begin
      case (bus_addr)
        `ABPC_REG_CTRL: hrdata = {31'h00000000, enable};
        `ABPC_REG_STAT: hrdata = {30'h00000000, status};
        `ABPC_REG_MASK: hrdata = {30'h00000000, mask};
        `ABPC_REG_ERA0: hrdata = err_addr[0];
        `ABPC_REG_ERD0: hrdata = err_det[0];
        `ABPC_REG_ERA1: hrdata = err_addr[1];
        `ABPC_REG_ERD1: hrdata = err_det[1];
        default: hrdata = 32'h00000000;
      endcase
    end
  end
endmodule // abpc_checker

// File: abpc_checker_chk.sv
// Checker of port gating and error responses of the protection checker.
`timescale 1ns/100ps
module abpc_chk (
  input wire hclk,
  input wire hresetn,
  input wire [1:0] p_hsel,
  input wire [3:0] p_htrans,
  input wire [1:0] p_hready,
  input wire [1:0] p_hreadyout,
  input wire [1:0] p_hresp,
  input wire [1:0] s_hsel,
  input wire [1:0] s_hreadyout,
  input wire [1:0] s_hresp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  genvar p;
  // Both ports get the same checks; the error is two cycles long.
  for (p = 0; p < 2; p = p + 1) begin : g_port
    wire take = p_hsel[p] && p_htrans[2*p+1] && p_hready[p];
    wire err1 = !p_hreadyout[p] && p_hresp[p];
    sequence s_deny; take && !s_hsel[p]; endsequence
    sequence s_err; err1 ##1 (p_hreadyout[p] && p_hresp[p]); endsequence
    a_deny_err_resp: assert property (s_deny |=> s_err)
      else $error("denied transfer lacks the two-cycle error");
    a_sel_needs_req: assert property (s_hsel[p] |-> p_hsel[p])
      else $error("slave selected without a request");
    a_err_blocks_sel: assert property (err1 |-> !s_hsel[p])
      else $error("slave selected during an error");
    a_err_has_cause: assert property (err1 |-> $past(take && !s_hsel[p]))
      else $error("error without a denied transfer");
    a_allow_resp_pass: assert property (take && s_hsel[p] |=>
      p_hreadyout[p] == s_hreadyout[p] && p_hresp[p] == s_hresp[p])
      else $error("allowed transfer response altered");
    a_err_no_stretch: assert property (err1 |=> !err1)
      else $error("error first cycle stretched");
  end
endmodule // abpc_chk
bind abpc_checker abpc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .p_hsel(p_hsel),
  .p_htrans(p_htrans), .p_hready(p_hready), .p_hreadyout(p_hreadyout), .p_hresp(p_hresp),
  .s_hsel(s_hsel), .s_hreadyout(s_hreadyout), .s_hresp(s_hresp));

// File: abpc_checker_tb.sv
// Testbench of the bus access protection checker.
`timescale 1ns/100ps
module abpc_checker_tb;
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rv;
  reg [1:0] htrans = 2'h0, p_hsel = 2'h0, p_hwrite = 2'h0, p_hprot_data = 2'h0;
  reg [1:0] p_hprot_priv = 2'h0, slow = 2'h0;
  reg [63:0] p_haddr = 64'h0;
  reg [3:0] p_htrans = 4'h0;
  reg [7:0] p_hmaster = 8'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq;
  wire [1:0] p_hreadyout, p_hresp, s_hsel, s_hreadyout, s_hresp;
  wire [15:0] seen;
  integer err_total = 0, n_compared = 0;
  always #50 hclk = ~hclk;
  abpc_checker DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .p_hsel(p_hsel),
    .p_haddr(p_haddr), .p_htrans(p_htrans), .p_hwrite(p_hwrite),
    .p_hprot_data(p_hprot_data), .p_hprot_priv(p_hprot_priv), .p_hmaster(p_hmaster),
    .p_hready(p_hreadyout), .p_hreadyout(p_hreadyout), .p_hresp(p_hresp), .s_hsel(s_hsel),
    .s_hreadyout(s_hreadyout), .s_hresp(s_hresp));
  abpc_slave_model u_slv (.hclk(hclk), .hresetn(hresetn), .s_hsel(s_hsel),
    .p_htrans(p_htrans), .p_hready(p_hreadyout), .slow(slow), .s_hreadyout(s_hreadyout),
    .s_hresp(s_hresp), .seen(seen));
  task chk(input ok, input string msg);
    begin
      n_compared++;
      if (!ok) begin
        err_total++;
        $display("[FAIL] %0t %0s", $time, msg);
      end
    end
  endtask
  // One single register transfer; read data is taken at the closing edge.
  task acc(input w, input [11:0] a, input [31:0] d);
    begin
      hsel <= 1'b1; haddr <= {20'h00000, a}; htrans <= 2'h2; hwrite <= w;
      @(posedge hclk); while (!hreadyout) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge hclk); while (!hreadyout) @(posedge hclk);
      rv = hrdata;
      chk(hresp === 1'b0, "register response");
    end
  endtask
  task rchk(input [11:0] a, input [31:0] e);
    begin
      acc(1'b0, a, 32'h0);
      chk(rv === e, "register read");
    end
  endtask
  // One monitored transfer; a denied one must end in error and never reach the slave.
  task xfer(input integer p, input [31:0] a, input w, dat, pv, input [3:0] m, input e);
    reg [7:0] n0;
    begin
      n0 = seen[8*p+:8];
      p_hsel[p] <= 1'b1; p_haddr[32*p+:32] <= a; p_htrans[2*p+:2] <= 2'h2;
      p_hwrite[p] <= w; p_hprot_data[p] <= dat; p_hprot_priv[p] <= pv; p_hmaster[4*p+:4] <= m;
      @(posedge hclk); while (!p_hreadyout[p]) @(posedge hclk);
      p_hsel[p] <= 1'b0; p_htrans[2*p+:2] <= 2'h0;
      @(posedge hclk); while (!p_hreadyout[p]) @(posedge hclk);
      chk(p_hresp[p] === e, "port response");
      chk(seen[8*p+:8] === n0 + {7'h00, !e}, "slave access count");
    end
  endtask
  task t_reset;
    begin
      xfer(0, 32'h40000000, 1'b1, 1'b0, 1'b0, 4'h5, 1'b0);
      rchk(12'h004, 32'h0);
      chk(irq === 1'b0, "interrupt after reset");
    end
  endtask
  task t_bounds;
    begin
      acc(1'b1, 12'h400, 32'h20000000);
      acc(1'b1, 12'h404, 32'h20000fe0);
      acc(1'b1, 12'h408, 32'h00000009);
      acc(1'b1, 12'h40c, 32'h1);
      acc(1'b1, 12'h008, 32'h3);
      acc(1'b1, 12'h000, 32'h1);
      rchk(12'h404, 32'h20000fff);
      xfer(0, 32'h20000ffc, 1'b0, 1'b1, 1'b1, 4'h0, 1'b0);
      xfer(0, 32'h20000000, 1'b0, 1'b1, 1'b0, 4'h0, 1'b0);
      xfer(0, 32'h20001000, 1'b0, 1'b1, 1'b1, 4'h0, 1'b1);
      xfer(0, 32'h20000010, 1'b1, 1'b1, 1'b1, 4'h0, 1'b1);
      xfer(0, 32'h20000010, 1'b0, 1'b0, 1'b1, 4'h0, 1'b1);
      xfer(0, 32'h20000010, 1'b0, 1'b1, 1'b1, 4'h2, 1'b1);
    end
  endtask
  task t_overlap;
    begin
      acc(1'b1, 12'h4f0, 32'h20000000);
      acc(1'b1, 12'h4f4, 32'h200000ff);
      acc(1'b1, 12'h4f8, 32'h000000ff);
      acc(1'b1, 12'h4fc, 32'h1);
      slow <= 2'h3;
      xfer(1, 32'h20000020, 1'b1, 1'b1, 1'b0, 4'h0, 1'b0);
      xfer(1, 32'h20000020, 1'b0, 1'b0, 1'b1, 4'h3, 1'b1);
      xfer(1, 32'h20000020, 1'b1, 1'b1, 1'b1, 4'h3, 1'b0);
      acc(1'b1, 12'h83c, 32'h0);
      rchk(12'h4f0, 32'h20000000);
      xfer(1, 32'h20000020, 1'b1, 1'b1, 1'b0, 4'h0, 1'b1);
      acc(1'b1, 12'h83c, 32'h00000010);
      xfer(1, 32'h20000020, 1'b1, 1'b1, 1'b0, 4'h0, 1'b0);
      acc(1'b1, 12'h4f8, 32'h000000ff);
      xfer(1, 32'h20000020, 1'b1, 1'b1, 1'b0, 4'h0, 1'b1);
      acc(1'b1, 12'h4fc, 32'h1);
      xfer(1, 32'h20000020, 1'b1, 1'b1, 1'b0, 4'h0, 1'b0);
      xfer(1, 32'h20000024, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
      xfer(1, 32'h20000024, 1'b0, 1'b1, 1'b1, 4'h3, 1'b0);
    end
  endtask
  task t_record;
    begin
      xfer(1, 32'h50000004, 1'b1, 1'b1, 1'b0, 4'h3, 1'b1);
      rchk(12'h018, 32'h50000004);
      rchk(12'h01c, 32'h00000033);
      rchk(12'h010, 32'h20000010);
      rchk(12'h014, 32'h00010026);
      rchk(12'h004, 32'h3);
      chk(irq === 1'b1, "interrupt raised");
      acc(1'b1, 12'h008, 32'h0);
      // The mask lands at the closing edge of the write, so look one edge later.
      @(posedge hclk);
      chk(irq === 1'b0, "interrupt masked");
      acc(1'b1, 12'h008, 32'h3);
      acc(1'b1, 12'h004, 32'h3);
      rchk(12'h004, 32'h0);
      chk(irq === 1'b0, "interrupt cleared");
      rchk(12'h0f0, 32'h0);
      // A reset in mid-run must bring the checker back to its open state.
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1, 32'h50000004, 1'b1, 1'b1, 1'b0, 4'h3, 1'b0);
      rchk(12'h000, 32'h0);
    end
  endtask
  task tally_and_finish;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Watchdog sized well above the hundred or so cycles the tests need.
  initial begin
    #(100 * 5000);
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_bounds;
    t_overlap;
    t_record;
    tally_and_finish;
  end
endmodule // abpc_checker_tb

// File: abpc_consts.vh
// Constants for the bus access protection checker.
`ifndef ABPC_CONSTS_VH
`define ABPC_CONSTS_VH
`define ABPC_NREG 16
`define ABPC_REG_CTRL 12'h000
`define ABPC_REG_STAT 12'h004
`define ABPC_REG_MASK 12'h008
`define ABPC_REG_ERA0 12'h010
`define ABPC_REG_ERD0 12'h014
`define ABPC_REG_ERA1 12'h018
`define ABPC_REG_ERD1 12'h01c
`define ABPC_RGD_BASE 12'h400
`define ABPC_ALT_BASE 12'h800
`define ABPC_W_START 2'h0
`define ABPC_W_END 2'h1
`define ABPC_W_ACC 2'h2
`define ABPC_W_VLD 2'h3
`define ABPC_GRAN_MASK 32'h0000001f
`define ABPC_BIT_SR 0
`define ABPC_BIT_SW 1
`define ABPC_BIT_SX 2
`define ABPC_BIT_UR 3
`define ABPC_BIT_UW 4
`define ABPC_BIT_UX 5
`define ABPC_BIT_NR 6
`define ABPC_BIT_NW 7
`define ABPC_ACC_W 8
`define ABPC_HRESP_OKAY 1'b0
`define ABPC_HRESP_ERROR 1'b1
`endif

// File: abpc_port_gate.v
// Per-port gate: forwards allowed transfers and returns a two-cycle error otherwise.
`timescale 1ns/100ps
`include "abpc_consts.vh"
module abpc_port_gate (
  input wire hclk,
  input wire hresetn,
  input wire m_hsel,
  input wire [1:0] m_htrans,
  input wire m_hready,
  input wire allow,
  input wire s_hreadyout,
  input wire s_hresp,
  output wire s_hsel,
  output wire m_hreadyout,
  output wire m_hresp,
  output wire fault
);
  localparam ST_IDLE = 2'b00;
  localparam ST_ERR1 = 2'b01;
  localparam ST_ERR2 = 2'b10;
  reg [1:0] state;
  wire req;
  assign req = m_hsel && m_htrans[1] && m_hready;
  // A denied transfer never raises the slave select.
  assign s_hsel = m_hsel && allow;
  assign fault = req && !allow;
  // Error response follows the two-cycle pattern the bus demands.
  assign m_hreadyout = (state == ST_ERR1) ? 1'b0 : (state == ST_ERR2) ? 1'b1 : s_hreadyout;
  assign m_hresp = (state == ST_IDLE) ? s_hresp : `ABPC_HRESP_ERROR;
  // Error sequencer.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= fault ? ST_ERR1 : ST_IDLE;
        ST_ERR1: state <= ST_ERR2;
        ST_ERR2: state <= fault ? ST_ERR1 : ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // abpc_port_gate

// File: abpc_region_match.v
// One region descriptor comparator: hit and grant for one reference.
`timescale 1ns/100ps
`include "abpc_consts.vh"
module abpc_region_match (
  input wire [31:0] addr,
  input wire [31:0] start_addr,
  input wire [31:0] end_addr,
  input wire [7:0] acc,
  input wire valid,
  input wire is_core,
  input wire priv,
  input wire is_write,
  input wire is_fetch,
  output wire hit,
  output wire grant
);
  wire core_ok;
  wire other_ok;
  // Bounds are inclusive; the end is taken at the top of its 32-byte block.
  assign hit = valid && (addr >= start_addr) && (addr <= (end_addr | `ABPC_GRAN_MASK));
  // core mode rights
  // Core rights split by mode; a fetch needs execute, not read.
  assign core_ok = priv ?
    (is_write ? acc[`ABPC_BIT_SW] : (is_fetch ? acc[`ABPC_BIT_SX] : acc[`ABPC_BIT_SR])) :
    (is_write ? acc[`ABPC_BIT_UW] : (is_fetch ? acc[`ABPC_BIT_UX] : acc[`ABPC_BIT_UR]));
  // non-core read write
  // Other masters have read and write only; a fetch from them never passes.
  assign other_ok = is_fetch ? 1'b0 : (is_write ? acc[`ABPC_BIT_NW] : acc[`ABPC_BIT_NR]);
  assign grant = hit && (is_core ? core_ok : other_ok);
endmodule // abpc_region_match

// File: abpc_slave_model.sv
// Protected slave pair behind the two gated ports.
`timescale 1ns/100ps
module abpc_slave_model (
  input wire hclk,
  input wire hresetn,
  input wire [1:0] s_hsel,
  input wire [3:0] p_htrans,
  input wire [1:0] p_hready,
  input wire [1:0] slow,
  output wire [1:0] s_hreadyout,
  output wire [1:0] s_hresp,
  output reg [15:0] seen
);
  reg [1:0] busy;
  integer i;
  // A slow slave adds one wait state; the count shows what reached the slave.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 2'h0;
      seen <= 16'h0000;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        busy[i] <= s_hsel[i] && p_htrans[2*i+1] && p_hready[i] && slow[i];
        if (s_hsel[i] && p_htrans[2*i+1] && p_hready[i]) begin
          seen[8*i+:8] <= seen[8*i+:8] + 8'h01;
        end
      end
    end
  end
  assign s_hreadyout = ~busy;
  // Slaves never refuse, so any error seen by a master came from the gate.
  assign s_hresp = 2'h0;
endmodule // abpc_slave_model
